// ==== verilog/vfmp_pkg.sv ====
// Summary of operation
// - Capability status read has no address; bits 7..2 are don't-care.
// - Capability status bit 1 always reads one: data FIFO is read-only.
// - Capability status bit 0 always reads one: data FIFO is present.
// - Data bytes buffered in a FIFO; each FIFO data read returns next.
// - FIFO data reads sustain one byte per three clocks: two waits then data.
// - Register write to 0x7E resets processor, pointer to zero, holds reset.
// - Repeated download data phases store bytes at successive RAM locations.
// - Register write to 0x7F with any data releases processor reset.
// - Register read of 0x8E resets processor to zero and holds reset.
// - Repeated upload data phases return successive program RAM bytes.
// - Command byte: select field 01, read/write bit, FIFO/register bit.
// - Register accesses may insert wait states up to 64 microseconds.
// - Writes leave the port busy about 200 ns; accesses during busy are terminated.
`default_nettype none
package vfmp_pkg;
    // Command byte layout
    localparam int CMD_SEL_HI = 7;
    localparam int CMD_SEL_LO = 6;
    localparam int CMD_RW_BIT = 5;
    localparam int CMD_FR_BIT = 4;
    localparam int CMD_UA_HI = 3;
    localparam int CMD_UA_LO = 0;
    localparam logic [1:0] DEV_SEL_VAL = 2'h1;
    localparam logic [3:0] UA_GENERAL = 4'h1;
    localparam logic [3:0] UA_FSTAT0 = 4'h0;
    localparam logic [3:0] UA_FSTAT1 = 4'h1;
    localparam logic [3:0] UA_FDATA = 4'h4;
    // Register addresses
    localparam logic [7:0] ADDR_UC_LOAD = 8'h7E;
    localparam logic [7:0] ADDR_UC_CLR = 8'h7F;
    localparam logic [7:0] ADDR_UC_READ = 8'h8E;
    // Capability status value
    localparam logic [7:0] FSTAT1_VAL = 8'h03;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // FIFO read pacing: one data cycle after two waits
    localparam int FIFO_WAITS = 2;
    // Internal write busy time
    localparam int BUSY_NS = 200;
    localparam int LINK_PERIOD_NS = 12;
    localparam int BUSY_CYC = (BUSY_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int REG_WAIT_US = 64;
    localparam int REG_WAIT_CYC = (REG_WAIT_US * 1000) / LINK_PERIOD_NS;

    typedef struct packed {
        logic [1:0] devSel;
        logic rdNotWr;
        logic fifoSel;
        logic [3:0] upperAddressNibble;
    } vfmp_cmd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } vfmp_byte_t;
endpackage : vfmp_pkg
`default_nettype wire

// ==== verilog/vfmp_sync.sv ====
`default_nettype none
// Two-flop level synchroniser
module vfmp_sync
    import vfmp_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk, // Destination clock
    input wire logic rstN, // Async reset, low
    input wire logic [W-1:0] din, // Level from other domain
    output logic [W-1:0] dout // Synchronised level
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            meta_r <= '0;
            dout <= '0;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule // vfmp_sync
`default_nettype wire

// ==== verilog/vfmp_vbi_fifo.sv ====
`default_nettype none
// Dual-clock byte FIFO with gray pointers
module vfmp_vbi_fifo
    import vfmp_pkg::*;
#(
    parameter int AW = 4
) (
    input wire logic wrClk, // Writer clock
    input wire logic wrRstN, // Writer reset, low
    input wire vfmp_byte_t wrIn, // Byte to store
    output logic wrFull, // No room
    input wire logic rdClk, // Reader clock
    input wire logic rdRstN, // Reader reset, low
    input wire logic rdTake, // Pop one byte
    output logic [7:0] rdData, // Head byte
    output logic rdEmpty // Nothing stored
);
    logic [7:0] mem [2**AW];
    logic [AW:0] wBin_r, wGray_r, rBin_r, rGray_r;
    logic [AW:0] rGrayW, wGrayR;
    logic [AW:0] wBinNxt, rBinNxt;

    assign wBinNxt = wBin_r + (AW+1)'(1);
    assign rBinNxt = rBin_r + (AW+1)'(1);
    assign wrFull = (wGray_r == {~rGrayW[AW:AW-1], rGrayW[AW-2:0]});
    assign rdEmpty = (rGray_r == wGrayR);
    assign rdData = mem[rBin_r[AW-1:0]];

    // Pointer crossings
    vfmp_sync #(.W(AW+1)) uRs (.clk(wrClk), .rstN(wrRstN), .din(rGray_r),
        .dout(rGrayW));
    vfmp_sync #(.W(AW+1)) uWs (.clk(rdClk), .rstN(rdRstN), .din(wGray_r),
        .dout(wGrayR));

    // Storage write
    always_ff @(posedge wrClk)
    begin
        if (wrIn.valid && !wrFull)
            mem[wBin_r[AW-1:0]] <= wrIn.data;
    end

    // Write pointer
    always_ff @(posedge wrClk or negedge wrRstN)
    begin
        if (!wrRstN)
        begin
            wBin_r <= '0;
            wGray_r <= '0;
        end
        else if (wrIn.valid && !wrFull)
        begin
            wBin_r <= wBinNxt;
            wGray_r <= wBinNxt ^ (wBinNxt >> 1);
        end
    end

    // Read pointer
    always_ff @(posedge rdClk or negedge rdRstN)
    begin
        if (!rdRstN)
        begin
            rBin_r <= '0;
            rGray_r <= '0;
        end
        else if (rdTake && !rdEmpty)
        begin
            rBin_r <= rBinNxt;
            rGray_r <= rBinNxt ^ (rBinNxt >> 1);
        end
    end
endmodule // vfmp_vbi_fifo
`default_nettype wire

// ==== verilog/vfmp_port.sv ====
`default_nettype none
// Host port command engine: FIFO status, VBI data, microcode transfer
module vfmp_port
    import vfmp_pkg::*;
#(
    parameter int FIFO_AW = 4,
    parameter int PRAM_AW = 10,
    parameter int REG_WAIT = REG_WAIT_CYC
) (
    input wire logic sys_clk, // Core clock
    input wire logic resetn, // Async reset, low
    input wire vfmp_byte_t vbiIn, // Sliced VBI byte from slicer
    output logic vbiFull, // VBI FIFO full, stalls slicer
    output logic cpuReset, // Embedded processor held in reset
    input wire logic [PRAM_AW-1:0] cpuAddr, // Processor fetch address
    output logic [7:0] cpuData, // Processor fetch data
    input wire logic linkClk, // Host port clock
    input wire logic linkRstN, // Link domain reset, low
    input wire logic phStart, // Phase strobe from host
    input wire logic phLast, // Host ends transfer after this phase
    input wire logic [7:0] hdIn, // Host data in
    output logic [7:0] hdOut, // Device data out
    output logic hdOe, // Device drives data bus
    output logic phAck, // Phase completes this cycle
    output logic phTerm // Access terminated by device
);
    typedef enum {
        ST_CMD, ST_ADDR, ST_FWAIT, ST_WDATA, ST_RDATA, ST_WAIT, ST_STR
    } vfmp_state_t;

    vfmp_state_t state_r;
    vfmp_cmd_t cmd_r;
    logic [7:0] addr_r;
    logic [1:0] waitCnt_r;
    logic [$clog2(REG_WAIT+1)-1:0] regCnt_r;
    logic [$clog2(BUSY_CYC+1)-1:0] busyCnt_r;
    logic [PRAM_AW-1:0] ptr_r;
    logic ucMode_r, ucModeSys;
    logic fifoTake, fifoEmpty;
    logic [7:0] fifoData;
    logic [7:0] pram [2**PRAM_AW];
    logic ramWe;
    logic [PRAM_AW-1:0] ptrNxt;
    vfmp_cmd_t cmdIn;

    assign cmdIn = vfmp_cmd_t'(hdIn);

    // Data FIFO between slicer and host port
    vfmp_vbi_fifo #(.AW(FIFO_AW)) uFifo (
        .wrClk(sys_clk),
        .wrRstN(resetn),
        .wrIn(vbiIn),
        .wrFull(vbiFull),
        .rdClk(linkClk),
        .rdRstN(linkRstN),
        .rdTake(fifoTake),
        .rdData(fifoData),
        .rdEmpty(fifoEmpty)
    );

    // Processor reset level crosses into core domain
    vfmp_sync #(.W(1)) uRst (
        .clk(sys_clk),
        .rstN(resetn),
        .din(ucMode_r),
        .dout(ucModeSys)
    );
    assign cpuReset = ucModeSys;

    // Byte pops when the paced data cycle completes
    assign fifoTake = (state_r == ST_STR) && (waitCnt_r == '0) && phStart
        && cmd_r.upperAddressNibble == UA_FDATA;
    assign ramWe = (state_r == ST_WDATA) && phStart;

    // Pointer after this edge, so upload data needs no extra cycle
    always_comb
    begin
        ptrNxt = ptr_r;
        if (state_r == ST_ADDR && phStart &&
            ((!cmd_r.rdNotWr && hdIn == ADDR_UC_LOAD) ||
            (cmd_r.rdNotWr && hdIn == ADDR_UC_READ)))
            ptrNxt = '0;
        else if ((state_r == ST_WDATA || state_r == ST_RDATA) && phStart)
            ptrNxt = ptr_r + 1'b1;
    end

    // Phase handshake outputs
    always_comb
    begin
        phAck = 1'b0;
        phTerm = 1'b0;
        hdOe = 1'b0;
        case (state_r)
            ST_CMD:
            begin
                phTerm = phStart && busyCnt_r != '0;
                phAck = phStart && busyCnt_r == '0 &&
                    cmdIn.devSel == DEV_SEL_VAL;
            end
            ST_ADDR: phAck = phStart;
            ST_WDATA: phAck = phStart;
            ST_RDATA: phAck = phStart;
            ST_WAIT: phAck = phStart && regCnt_r == '0;
            ST_STR: phAck = phStart && waitCnt_r == '0;
            default: phAck = 1'b0;
        endcase
        hdOe = phAck && (state_r == ST_RDATA || state_r == ST_STR ||
            state_r == ST_WAIT);
    end

    // Program RAM: host side port
    always_ff @(posedge linkClk)
    begin
        if (ramWe && ucMode_r)
            pram[ptr_r] <= hdIn;
    end

    // Processor fetch port, used only outside transfers
    always_ff @(posedge sys_clk)
    begin
        cpuData <= pram[cpuAddr];
    end

    // Phase sequencer
    always_ff @(posedge linkClk or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            state_r <= ST_CMD;
            cmd_r <= '0;
            addr_r <= BYTE_ZERO;
            waitCnt_r <= '0;
            regCnt_r <= '0;
        end
        else
        begin
            case (state_r)
                ST_CMD:
                    if (phStart && busyCnt_r == '0 &&
                        cmdIn.devSel == DEV_SEL_VAL)
                    begin
                        cmd_r <= cmdIn;
                        if (cmdIn.fifoSel)
                        begin
                            state_r <= ST_STR;
                            waitCnt_r <= 2'(FIFO_WAITS);
                        end
                        else
                            state_r <= ST_ADDR;
                    end
                ST_ADDR:
                    if (phStart)
                    begin
                        addr_r <= hdIn;
                        regCnt_r <= '0;
                        if (!cmd_r.rdNotWr)
                            state_r <= ST_WDATA;
                        else if (hdIn == ADDR_UC_READ)
                            state_r <= ST_RDATA;
                        else
                        begin
                            state_r <= ST_WAIT;
                            regCnt_r <= ($bits(regCnt_r))'(REG_WAIT);
                        end
                    end
                ST_WDATA, ST_RDATA:
                    if (phStart && phLast)
                        state_r <= ST_CMD;
                ST_WAIT:
                    if (regCnt_r != '0)
                        regCnt_r <= regCnt_r - 1'b1;
                    else if (phStart)
                        state_r <= ST_CMD;
                ST_STR:
                    if (waitCnt_r != '0)
                        waitCnt_r <= waitCnt_r - 1'b1;
                    else if (phStart)
                    begin
                        waitCnt_r <= 2'(FIFO_WAITS);
                        if (phLast)
                            state_r <= ST_CMD;
                    end
                default: state_r <= ST_CMD;
            endcase
        end
    end

    // Microcode mode, pointer and internal busy time
    always_ff @(posedge linkClk or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            ucMode_r <= 1'b0;
            ptr_r <= '0;
            busyCnt_r <= '0;
        end
        else
        begin
            if (busyCnt_r != '0)
                busyCnt_r <= busyCnt_r - 1'b1;
            if (state_r == ST_ADDR && phStart)
            begin
                if (!cmd_r.rdNotWr && hdIn == ADDR_UC_LOAD)
                begin
                    ucMode_r <= 1'b1;
                    ptr_r <= '0;
                end
                else if (cmd_r.rdNotWr && hdIn == ADDR_UC_READ)
                begin
                    ucMode_r <= 1'b1;
                    ptr_r <= '0;
                end
                else if (!cmd_r.rdNotWr && hdIn == ADDR_UC_CLR)
                    ucMode_r <= 1'b0;
            end
            if ((state_r == ST_WDATA || state_r == ST_RDATA) && phStart)
            begin
                ptr_r <= ptr_r + 1'b1;
                if (state_r == ST_WDATA && phLast)
                    busyCnt_r <= ($bits(busyCnt_r))'(BUSY_CYC);
            end
        end
    end

    // Read data mux, registered
    always_ff @(posedge linkClk or negedge linkRstN)
    begin
        if (!linkRstN)
            hdOut <= BYTE_ZERO;
        else if (state_r == ST_STR)
        begin
            if (cmd_r.upperAddressNibble == UA_FSTAT1)
                hdOut <= FSTAT1_VAL;
            else if (cmd_r.upperAddressNibble == UA_FDATA)
                hdOut <= fifoEmpty ? BYTE_ZERO : fifoData;
            else
                hdOut <= {3'h0, !fifoEmpty, 3'h0, 1'b0};
        end
        else if (state_r == ST_RDATA || (state_r == ST_ADDR && phStart
            && cmd_r.rdNotWr && hdIn == ADDR_UC_READ))
            hdOut <= pram[ptrNxt];
        else
            hdOut <= BYTE_ZERO;
    end

    // Checks
    AST_CLR_RELEASES: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_ADDR && phStart && !cmd_r.rdNotWr
        && hdIn == ADDR_UC_CLR |=> !ucMode_r)
        else $error("clear reset did not release processor");
    AST_LOAD_HOLDS: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_ADDR && phStart && !cmd_r.rdNotWr
        && hdIn == ADDR_UC_LOAD |=> ucMode_r && ptr_r == '0)
        else $error("download did not reset processor");
    AST_UPLOAD_HOLDS: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_ADDR && phStart && cmd_r.rdNotWr
        && hdIn == ADDR_UC_READ |=> ucMode_r && ptr_r == '0)
        else $error("upload did not reset processor");
    AST_PTR_STEP: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_WDATA && phStart |=> ptr_r == $past(ptr_r) + 1'b1)
        else $error("pointer did not advance");
    AST_UP_STEP: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_RDATA && phStart |=> ptr_r == $past(ptr_r) + 1'b1)
        else $error("upload pointer did not advance");
    AST_STAT1: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_STR && cmd_r.upperAddressNibble == UA_FSTAT1
        |=> hdOut[1:0] == 2'h3)
        else $error("capability bits not one");
    AST_PACE: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        fifoTake && !phLast |=> !phAck [*2])
        else $error("FIFO read not paced");
    AST_BUSY_TERM: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_CMD && phStart && busyCnt_r != '0
        |-> phTerm && !phAck)
        else $error("busy access not terminated");
    AST_SEL: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_CMD && phStart && cmdIn.devSel != DEV_SEL_VAL
        |=> state_r == ST_CMD)
        else $error("foreign select accepted");
    AST_CMD_ACK: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_CMD && phStart && busyCnt_r == '0
        && cmdIn.devSel == DEV_SEL_VAL |-> phAck && !phTerm)
        else $error("valid command not acknowledged");
    AST_STR_WAIT: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_STR && waitCnt_r != '0 |-> !phAck)
        else $error("FIFO data cycle without wait cycles");
    AST_UP_HELD: assert property (@(posedge linkClk)
        disable iff (!linkRstN)
        state_r == ST_RDATA |-> ucMode_r)
        else $error("upload ran with processor released");
    COV_LOAD: cover property (@(posedge linkClk) ramWe && phLast);
    COV_UPLOAD: cover property (@(posedge linkClk)
        state_r == ST_RDATA && phStart);
    COV_FIFO: cover property (@(posedge linkClk) fifoTake);
    COV_TERM: cover property (@(posedge linkClk) phTerm);
endmodule // vfmp_port
`default_nettype wire

// ==== verification/vfmp_host_model.sv ====
`default_nettype none
// Host side of the port: issues phases on the link clock
module vfmp_host_model
    import vfmp_pkg::*;
(
    input wire logic linkClk, // Port clock
    output logic phStart, // Phase strobe
    output logic phLast, // Final data phase
    output logic [7:0] hdIn, // Byte to device
    input wire logic [7:0] hdOut, // Byte from device
    input wire logic hdOe, // Device drives bus
    input wire logic phAck, // Phase done
    input wire logic phTerm // Access terminated
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hostOe;
    logic [7:0] hostByte;
    logic lastOe;

    // Released bus shows the inverse of the last byte, never a stale copy
    assign hdIn = hostOe ? hostByte : ~hostByte;

    // Idle state at time zero
    initial
    begin
        phStart = 1'b0;
        phLast = 1'b0;
        hostOe = 1'b0;
        hostByte = 8'h00;
        lastOe = 1'b0;
    end

    // One phase, held until acked, terminated or the wait runs out
    task automatic phase(input logic [7:0] d, input logic last,
        input logic drv, input int maxWait, output logic [7:0] rd,
        output logic [1:0] res, output int waits);
        waits = 0;
        phStart = 1'b1;
        phLast = last;
        hostOe = drv;
        hostByte = d;
        // Answers are looked at mid-cycle, where they have settled
        @(negedge linkClk);
        while (phAck !== 1'b1 && phTerm !== 1'b1 && waits < maxWait)
        begin
            waits++;
            @(negedge linkClk);
        end
        rd = hdOut;
        lastOe = hdOe;
        res = (phAck === 1'b1) ? 2'h1 : ((phTerm === 1'b1) ? 2'h2 : 2'h0);
        // The phase is taken at this rising edge; change only after it
        @(posedge linkClk);
        #1;
    endtask

    // Drop the strobe between transfers
    task automatic idle();
        phStart = 1'b0;
        phLast = 1'b0;
        hostOe = 1'b0;
    endtask
endmodule // vfmp_host_model
`default_nettype wire

// ==== verification/vfmp_port_bench.sv ====
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        nChecks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("unexpected %s exp %0h got %0h", nm, exp, got); \
        end \
    end
// Self-checking bench for the host port command engine
module vfmp_port_bench
    import vfmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REGW = 8;
    localparam int NUC = 12;
    localparam logic [7:0] CMD_ST1 = {DEV_SEL_VAL, 2'b11, UA_FSTAT1};
    localparam logic [7:0] CMD_FIFO = {DEV_SEL_VAL, 2'b11, UA_FDATA};
    localparam logic [7:0] CMD_RD = {DEV_SEL_VAL, 2'b10, UA_GENERAL};
    localparam logic [7:0] CMD_WR = {DEV_SEL_VAL, 2'b00, UA_GENERAL};
    logic sys_clk, resetn, linkClk, linkRstN;
    vfmp_byte_t vbiIn;
    logic vbiFull, cpuReset, phStart, phLast, hdOe, phAck, phTerm;
    logic [9:0] cpuAddr;
    logic [7:0] cpuData, hdIn, hdOut, rd;
    logic [1:0] res;
    logic [7:0] vbiQ[$];
    logic [7:0] ucode[NUC];
    int w, fails, nChecks;

    // Core and link clocks, unrelated in phase
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    initial linkClk = 1'b0;
    always #6 linkClk = ~linkClk;

    vfmp_port #(.FIFO_AW(4), .PRAM_AW(10), .REG_WAIT(REGW)) vfmp_port_i (
        .sys_clk(sys_clk), .resetn(resetn), .vbiIn(vbiIn),
        .vbiFull(vbiFull), .cpuReset(cpuReset), .cpuAddr(cpuAddr),
        .cpuData(cpuData), .linkClk(linkClk), .linkRstN(linkRstN),
        .phStart(phStart), .phLast(phLast), .hdIn(hdIn), .hdOut(hdOut),
        .hdOe(hdOe), .phAck(phAck), .phTerm(phTerm));

    vfmp_host_model vfmp_host_model_i (
        .linkClk(linkClk), .phStart(phStart), .phLast(phLast),
        .hdIn(hdIn), .hdOut(hdOut), .hdOe(hdOe), .phAck(phAck),
        .phTerm(phTerm));

    // Counts, verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Wait whole link cycles, then step off the edge
    task automatic link(input int n);
        repeat (n) @(posedge linkClk);
        #1;
    endtask

    // One phase with its expected outcome
    task automatic ph(input logic [7:0] d, input logic last, input logic drv,
        input logic [1:0] expRes);
        vfmp_host_model_i.phase(d, last, drv, 40, rd, res, w);
        `CHK("phase result", expRes, res)
    endtask

    // Clear-reset write with arbitrary data
    task automatic clr();
        ph(CMD_WR, 1'b0, 1'b1, 2'h1);
        ph(ADDR_UC_CLR, 1'b0, 1'b1, 2'h1);
        ph(8'($urandom), 1'b1, 1'b1, 2'h1);
        vfmp_host_model_i.idle();
        link(30);
        `CHK("processor running", 1'b0, cpuReset)
    endtask

    // Hang guard
    initial
    begin
        #1000000;
        fails++;
        close_out();
    end

    // Main sequence
    initial
    begin
        fails = 0;
        nChecks = 0;
        resetn = 1'b0;
        linkRstN = 1'b0;
        vbiIn = '0;
        cpuAddr = '0;
        void'($urandom(32'hFA18));
        repeat (12) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        linkRstN = 1'b1;
        link(3);
        // Capability status, then a command with a foreign select field
        ph(CMD_ST1, 1'b0, 1'b1, 2'h1);
        ph(8'h00, 1'b1, 1'b0, 2'h1);
        `CHK("status bits", 2'h3, rd[1:0])
        `CHK("status drive", 1'b1, vfmp_host_model_i.lastOe)
        ph(8'hB1, 1'b0, 1'b1, 2'h0);
        vfmp_host_model_i.idle();
        // Fill the data FIFO from the slicer side until it refuses
        @(posedge sys_clk);
        #1;
        while (vbiFull !== 1'b1 && vbiQ.size() < 40)
        begin
            vbiIn = {1'b1, 8'($urandom)};
            vbiQ.push_back(vbiIn.data);
            @(posedge sys_clk);
            #1;
        end
        vbiIn.valid = 1'b0;
        `CHK("fifo full", 1'b1, vbiFull)
        link(8);
        // Drain it, checking order and pacing
        ph(CMD_FIFO, 1'b0, 1'b1, 2'h1);
        foreach (vbiQ[i])
        begin
            ph(8'h00, i == vbiQ.size() - 1, 1'b0, 2'h1);
            `CHK("fifo byte", vbiQ[i], rd)
            `CHK("fifo waits", FIFO_WAITS, w)
        end
        ph(CMD_FIFO, 1'b0, 1'b1, 2'h1);
        ph(8'h00, 1'b1, 1'b0, 2'h1);
        `CHK("empty read", BYTE_ZERO, rd)
        // Download, then an access while the write is still busy
        foreach (ucode[i])
            ucode[i] = 8'($urandom);
        ph(CMD_WR, 1'b0, 1'b1, 2'h1);
        ph(ADDR_UC_LOAD, 1'b0, 1'b1, 2'h1);
        foreach (ucode[i])
            ph(ucode[i], i == NUC - 1, 1'b1, 2'h1);
        ph(CMD_ST1, 1'b0, 1'b1, 2'h2);
        vfmp_host_model_i.idle();
        link(30);
        `CHK("held in reset", 1'b1, cpuReset)
        clr();
        // Processor fetches see the bytes at successive locations
        for (int k = 0; k < NUC; k++)
        begin
            @(posedge sys_clk);
            #1;
            cpuAddr = 10'(k);
            repeat (2) @(posedge sys_clk);
            #1;
            `CHK("program byte", ucode[k], cpuData)
        end
        // Upload from location zero, every byte checked
        link(1);
        ph(CMD_RD, 1'b0, 1'b1, 2'h1);
        ph(ADDR_UC_READ, 1'b0, 1'b1, 2'h1);
        for (int k = 0; k < NUC; k++)
        begin
            ph(8'h00, k == NUC - 1, 1'b0, 2'h1);
            `CHK("upload byte", ucode[k], rd)
        end
        vfmp_host_model_i.idle();
        link(12);
        `CHK("upload reset", 1'b1, cpuReset)
        clr();
        // Ordinary register read completes after its wait states
        ph(CMD_RD, 1'b0, 1'b1, 2'h1);
        ph(8'h10, 1'b0, 1'b1, 2'h1);
        ph(8'h00, 1'b1, 1'b0, 2'h1);
        `CHK("reg wait", REGW, w)
        vfmp_host_model_i.idle();
        link(4);
        close_out();
    end
endmodule // vfmp_port_bench
`default_nettype wire
